// >>> verilog/jdap_params.svh
// Constants for the test access and debug entry block
`ifndef JDAP_PARAMS_SVH
`define JDAP_PARAMS_SVH
`define JDAP_IR_W        4
`define JDAP_IR_RESET    4'hF
`define JDAP_IR_CAPTURE  4'h1
`define JDAP_IR_BYPASS   4'hF
`define JDAP_IR_DBGCMD   4'h7
`define JDAP_IR_DBGSTAT  4'h6
`define JDAP_DR_W        32
`define JDAP_DR_ZERO     32'h0000_0000
`define JDAP_ACK_CYCLES  2'h3
`define JDAP_ADDR_W      8
`define JDAP_CMD_READ    1'h0
`define JDAP_CMD_WRITE   1'h1
`define JDAP_CMD_BIT     31
`define JDAP_ADDR_MSB    30
`define JDAP_ADDR_LSB    23
`define JDAP_WDATA_MSB   22
`define JDAP_WDATA_LSB   0
`define JDAP_WDATA_W     23
`endif

// >>> verilog/jdap_pkg.sv
// Types for the test access and debug entry block
package jdap_pkg;
  typedef enum logic [3:0] {
    JDAP_TLR   = 4'h0,
    JDAP_RTI   = 4'h1,
    JDAP_SELDR = 4'h3,
    JDAP_CAPDR = 4'h2,
    JDAP_SHDR  = 4'h6,
    JDAP_EX1DR = 4'h7,
    JDAP_PDR   = 4'h5,
    JDAP_EX2DR = 4'h4,
    JDAP_UPDR  = 4'hC,
    JDAP_SELIR = 4'hD,
    JDAP_CAPIR = 4'hF,
    JDAP_SHIR  = 4'hE,
    JDAP_EX1IR = 4'hA,
    JDAP_PIR   = 4'hB,
    JDAP_EX2IR = 4'h9,
    JDAP_UPIR  = 4'h8
  } jdap_tap_t;
endpackage : jdap_pkg

// >>> verilog/jdap_top.sv
// Test access port and debug entry logic
//////////////////////////////////////////////////////////////////////////////
`include "jdap_params.svh"
module jdap_top
  import jdap_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      resetn,
  input  wire logic                      tck,
  input  wire logic                      tms,
  input  wire logic                      tdi,
  input  wire logic                      trstn,
  output logic                           tdo_o,
  output logic                           tdo_oe,
  input  wire logic                      debug_event_pin_i,
  output logic                           debug_event_pin_o,
  output logic                           debug_event_pin_oe,
  input  wire logic                      core_instr_done,
  input  wire logic                      core_bkpt_hit,
  output logic                           core_halt_req,
  output logic                           core_in_debug,
  output logic                           core_resume,
  output logic                           dbg_req,
  output logic                           dbg_we,
  output logic [`JDAP_ADDR_W-1:0]        dbg_addr,
  output logic [`JDAP_WDATA_W-1:0]       dbg_wdata,
  input  wire logic [`JDAP_DR_W-1:0]     dbg_rdata
);
  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers: first stage read only by second
  // TCK must stay high and low for more than one mclk cycle each, or edges can be lost
  logic [2:0] s1_ff;
  logic [2:0] s2_ff;
  logic       s3_tck_ff;
  logic       trst_s1_ff;
  logic       trst_s2_ff;
  logic       de_s1_ff;
  logic       de_s2_ff;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_ff     <= 3'h0;
      s2_ff     <= 3'h0;
      s3_tck_ff <= 1'b0;
    end
    else
    begin
      s1_ff     <= {tck, tms, tdi};
      s2_ff     <= s1_ff;
      s3_tck_ff <= s2_ff[2];
    end
  end
  // Event pin idles high on its pull-up, so its stages reset to one
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      de_s1_ff <= 1'b1;
      de_s2_ff <= 1'b1;
    end
    else
    begin
      de_s1_ff <= debug_event_pin_i;
      de_s2_ff <= de_s1_ff;
    end
  end
  // Test reset bypasses the sampler so it acts without any test clock edge
  always_ff @(posedge mclk or negedge trstn)
  begin
    if (!trstn)
    begin
      trst_s1_ff <= 1'b1;
      trst_s2_ff <= 1'b1;
    end
    else
    begin
      trst_s1_ff <= 1'b0;
      trst_s2_ff <= trst_s1_ff;
    end
  end
  wire tms_s   = s2_ff[1];
  wire tdi_s   = s2_ff[0];
  wire tck_ris = s2_ff[2] & ~s3_tck_ff;
  wire tck_fal = ~s2_ff[2] & s3_tck_ff;
  wire trst_a  = trst_s2_ff;

  //////////////////////////////////////////////////////////////////////////////
  // TAP controller
  jdap_tap_t tap_ff;
  jdap_tap_t nxt_tap;
  function automatic jdap_tap_t jdap_step(input jdap_tap_t s, input logic m);
    case (s)
      JDAP_TLR:   jdap_step = m ? JDAP_TLR   : JDAP_RTI;
      JDAP_RTI:   jdap_step = m ? JDAP_SELDR : JDAP_RTI;
      JDAP_SELDR: jdap_step = m ? JDAP_SELIR : JDAP_CAPDR;
      JDAP_CAPDR: jdap_step = m ? JDAP_EX1DR : JDAP_SHDR;
      JDAP_SHDR:  jdap_step = m ? JDAP_EX1DR : JDAP_SHDR;
      JDAP_EX1DR: jdap_step = m ? JDAP_UPDR  : JDAP_PDR;
      JDAP_PDR:   jdap_step = m ? JDAP_EX2DR : JDAP_PDR;
      JDAP_EX2DR: jdap_step = m ? JDAP_UPDR  : JDAP_SHDR;
      JDAP_UPDR:  jdap_step = m ? JDAP_SELDR : JDAP_RTI;
      JDAP_SELIR: jdap_step = m ? JDAP_TLR   : JDAP_CAPIR;
      JDAP_CAPIR: jdap_step = m ? JDAP_EX1IR : JDAP_SHIR;
      JDAP_SHIR:  jdap_step = m ? JDAP_EX1IR : JDAP_SHIR;
      JDAP_EX1IR: jdap_step = m ? JDAP_UPIR  : JDAP_PIR;
      JDAP_PIR:   jdap_step = m ? JDAP_EX2IR : JDAP_PIR;
      JDAP_EX2IR: jdap_step = m ? JDAP_UPIR  : JDAP_SHIR;
      JDAP_UPIR:  jdap_step = m ? JDAP_SELDR : JDAP_RTI;
      default:    jdap_step = JDAP_TLR;
    endcase
  endfunction : jdap_step
  assign nxt_tap = tck_ris ? jdap_step(tap_ff, tms_s) : tap_ff;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      tap_ff <= JDAP_TLR;
    else if (trst_a)
      tap_ff <= JDAP_TLR;
    else
      tap_ff <= nxt_tap;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Instruction and data registers
  logic [`JDAP_IR_W-1:0] ir_sh_ff;
  logic [`JDAP_IR_W-1:0] ir_ff;
  logic [`JDAP_DR_W-1:0] dr_ff;
  logic                  in_debug_ff;
  wire sel_cmd  = (ir_ff == `JDAP_IR_DBGCMD);
  wire sel_stat = (ir_ff == `JDAP_IR_DBGSTAT);
  wire sel_byp  = ~sel_cmd & ~sel_stat;
  wire sh_ir    = (tap_ff == JDAP_SHIR);
  wire sh_dr    = (tap_ff == JDAP_SHDR);
  wire [`JDAP_DR_W-1:0] cap_val = sel_cmd ? dbg_rdata : {{(`JDAP_DR_W-1){1'b0}}, in_debug_ff};
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ir_sh_ff <= `JDAP_IR_RESET;
      ir_ff    <= `JDAP_IR_RESET;
      dr_ff    <= `JDAP_DR_ZERO;
    end
    else if (trst_a || tap_ff == JDAP_TLR)
      ir_ff    <= `JDAP_IR_RESET;
    else if (tck_ris)
    begin
      if (tap_ff == JDAP_CAPIR)
        ir_sh_ff <= `JDAP_IR_CAPTURE;
      else if (sh_ir)
        ir_sh_ff <= {tdi_s, ir_sh_ff[`JDAP_IR_W-1:1]};
      else if (tap_ff == JDAP_UPIR)
        ir_ff <= ir_sh_ff;
      if (tap_ff == JDAP_CAPDR)
        dr_ff <= sel_byp ? `JDAP_DR_ZERO : cap_val;
      else if (sh_dr && sel_byp)
        dr_ff[0] <= tdi_s;
      else if (sh_dr)
        dr_ff <= {tdi_s, dr_ff[`JDAP_DR_W-1:1]};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial output, updated on falling test clock; test reset also clears the enable
  wire tdo_bit = sh_ir ? ir_sh_ff[0] : dr_ff[0];
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      tdo_o  <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (trst_a)
      tdo_oe <= 1'b0;
    else if (tck_fal)
    begin
      tdo_o  <= tdo_bit;
      tdo_oe <= sh_ir | sh_dr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Debug access: commands only arrive by Update-DR on the command register
  wire upd_cmd = tck_ris & (tap_ff == JDAP_UPDR) & sel_cmd;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      dbg_req   <= 1'b0;
      dbg_we    <= 1'b0;
      dbg_addr  <= {`JDAP_ADDR_W{1'b0}};
      dbg_wdata <= {`JDAP_WDATA_W{1'b0}};
    end
    else
    begin
      dbg_req <= upd_cmd & in_debug_ff;
      if (upd_cmd)
      begin
        dbg_we    <= (dr_ff[`JDAP_CMD_BIT] == `JDAP_CMD_WRITE);
        dbg_addr  <= dr_ff[`JDAP_ADDR_MSB:`JDAP_ADDR_LSB];
        dbg_wdata <= dr_ff[`JDAP_WDATA_MSB:`JDAP_WDATA_LSB];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Debug entry; event pin is independent of the TAP state
  logic       halt_ff;
  logic [1:0] ack_cnt_ff;
  logic       oe_d1_ff;
  logic       oe_d2_ff;
  // Own pull stays in the pin synchroniser two cycles after release; mask it
  wire own_pull = debug_event_pin_oe | oe_d1_ff | oe_d2_ff;
  wire ext_req  = ~de_s2_ff & ~own_pull;
  wire enter    = ~in_debug_ff & ((halt_ff & core_instr_done) | core_bkpt_hit);
  // An all-zero command word is the resume command
  wire resume   = upd_cmd & (dr_ff == `JDAP_DR_ZERO) & in_debug_ff;
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      oe_d1_ff <= 1'b0;
      oe_d2_ff <= 1'b0;
    end
    else
    begin
      oe_d1_ff <= debug_event_pin_oe;
      oe_d2_ff <= oe_d1_ff;
    end
  end

  // Entry consumes the request; a stale one would halt the core after resume
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      halt_ff <= 1'b0;
    else if (enter)
      halt_ff <= 1'b0;
    else if (ext_req && !in_debug_ff)
      halt_ff <= 1'b1;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      in_debug_ff <= 1'b0;
      core_resume <= 1'b0;
    end
    else
    begin
      core_resume <= resume;
      if (enter)
        in_debug_ff <= 1'b1;
      else if (resume)
        in_debug_ff <= 1'b0;
    end
  end

  // Counted in device clocks, since the test clock may be stopped
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ack_cnt_ff         <= 2'h0;
      debug_event_pin_oe <= 1'b0;
    end
    else if (enter)
    begin
      ack_cnt_ff         <= `JDAP_ACK_CYCLES - 2'h1;
      debug_event_pin_oe <= 1'b1;
    end
    else if (ack_cnt_ff != 2'h0)
      ack_cnt_ff <= ack_cnt_ff - 2'h1;
    else
      debug_event_pin_oe <= 1'b0;
  end
  // Open drain: data is always low, only the enable moves
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      debug_event_pin_o <= 1'b0;
      core_halt_req     <= 1'b0;
      core_in_debug     <= 1'b0;
    end
    else
    begin
      debug_event_pin_o <= 1'b0;
      core_halt_req     <= halt_ff | ext_req;
      core_in_debug     <= in_debug_ff;
    end
  end
endmodule : jdap_top

// >>> verification/jdap_jtag_model.sv
// Outside test controller that drives the serial test port
module jdap_jtag_model (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trstn,
  input  wire logic tdo_o,
  input  wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic oe_ok;
  initial
  begin
    {tck, tms, tdi, trstn} = 4'h6;
    #2us trstn = 1'h1;
  end
  //////////////////////////////////////////////////////////////////////////////
  // One test clock period; clock stands still between calls
  task automatic step(input logic m, input logic d, output logic q);
    {tms, tdi} = {m, d};
    #200ns q = tdo_o;
    oe_ok &= tdo_oe;
    tck = 1'h1;
    #200ns tck = 1'h0;
  endtask : step
  task automatic walk(input logic [7:0] t, input int n);
    logic q;
    for (int i = 0; i < n; i++)
      step(t[i], 1'h1, q);
  endtask : walk
  // Whole scans only, from and back to idle
  task automatic scan(input logic ir, input logic [31:0] d, input int n, output logic [31:0] q, output logic ok);
    #($urandom_range(49, 1) * 1ns);
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    oe_ok = 1'h1;
    q = 32'h0;
    for (int i = 0; i < n; i++)
      step(i == n - 1, d[i], q[i]);
    ok = oe_ok;
    walk(8'h01, 2);
  endtask : scan
  task automatic trst();
    trstn = 1'h0;
    #300ns trstn = 1'h1;
    walk(8'h00, 1);
  endtask : trst
endmodule : jdap_jtag_model

// >>> verification/jdap_top_asserts.sv
// Concurrent checks on the test port and debug entry pins
module jdap_top_asserts (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic tck,
  input wire logic trstn,
  input wire logic tdo_o,
  input wire logic tdo_oe,
  input wire logic debug_event_pin_i,
  input wire logic debug_event_pin_o,
  input wire logic debug_event_pin_oe,
  input wire logic core_instr_done,
  input wire logic core_halt_req,
  input wire logic core_in_debug,
  input wire logic dbg_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////////////
  oe_three_a: assert property ($rose(debug_event_pin_oe) |-> debug_event_pin_oe[*3] ##1 !debug_event_pin_oe)
    else $error("ack pulse not three cycles");
  pin_low_a: assert property (debug_event_pin_oe |-> !debug_event_pin_o)
    else $error("event pin driven high");
  tdo_fall_a: assert property (tdo_oe && $changed(tdo_o) |-> !$past(tck, 2))
    else $error("tdo moved after a rising test clock");
  trst_off_a: assert property (!trstn |-> ##[0:2] !tdo_oe)
    else $error("tdo driven under test reset");
  halt_ask_a: assert property ($fell(debug_event_pin_i) && !debug_event_pin_oe && !core_in_debug |-> ##[1:3] core_halt_req)
    else $error("no halt after pin request");
  entry_ack_a: assert property (core_halt_req && core_instr_done && !core_in_debug && !debug_event_pin_oe
    |-> ##[1:2] $rose(debug_event_pin_oe))
    else $error("no ack on debug entry");
  in_debug_a: assert property ($rose(debug_event_pin_oe) |-> ##[0:2] core_in_debug)
    else $error("ack without debug mode");
  req_pulse_a: assert property (dbg_req |-> core_in_debug ##1 !dbg_req)
    else $error("access outside debug or too long");
  cover property ($rose(debug_event_pin_oe));
  cover property (dbg_req);
  cover property ($fell(core_in_debug));
endmodule : jdap_top_asserts
//////////////////////////////////////////////////////////////////////////////
bind jdap_top jdap_top_asserts jdap_top_asserts_i (.mclk, .resetn, .tck, .trstn, .tdo_o, .tdo_oe,
  .debug_event_pin_i, .debug_event_pin_o, .debug_event_pin_oe, .core_instr_done, .core_halt_req,
  .core_in_debug, .dbg_req);

// >>> verification/jdap_top_tb.sv
// Self-checking bench for the test access and debug entry block
`include "jdap_params.svh"
module jdap_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'h0;
  logic        resetn = 1'h0;
  logic        ext_pull = 1'h0;
  logic        core_instr_done = 1'h0;
  logic        core_bkpt_hit = 1'h0;
  logic [31:0] dbg_rdata = 32'h0;
  logic [31:0] q, w, r;
  logic        ok;
  wire         tck, tms, tdi, trstn, tdo_o, tdo_oe, debug_event_pin_o, debug_event_pin_oe;
  wire         core_halt_req, core_in_debug, core_resume, dbg_req, dbg_we;
  wire  [7:0]  dbg_addr;
  wire  [22:0] dbg_wdata;
  wire  [2:0]  evt = {!core_in_debug, core_in_debug, core_halt_req};
  int          n_mismatch = 0, checks_done = 0, nreq = 0, width = 0, ents = 0, nres = 0;
  // Open-drain pin with pull-up
  wire         pin = !(ext_pull || (debug_event_pin_oe && !debug_event_pin_o));
  jdap_top jdap_top_i (.mclk, .resetn, .tck, .tms, .tdi, .trstn, .tdo_o, .tdo_oe, .debug_event_pin_i(pin),
    .debug_event_pin_o, .debug_event_pin_oe, .core_instr_done, .core_bkpt_hit, .core_halt_req, .core_in_debug,
    .core_resume, .dbg_req, .dbg_we, .dbg_addr, .dbg_wdata, .dbg_rdata);
  jdap_jtag_model jdap_jtag_model_i (.tck, .tms, .tdi, .trstn, .tdo_o, .tdo_oe);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp=%h seen=%h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    if (n_mismatch == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  function automatic logic [31:0] field(input logic [31:0] v, input int lo, input int n);
    return (v >> lo) & ((32'h1 << n) - 32'h1);
  endfunction : field
  // Bounded wait on halt, entry or exit
  task automatic wait_ev(input int k);
    @(posedge mclk);
    for (int i = 0; i < 40 && evt[k] !== 1'h1; i++)
      @(posedge mclk);
    #5ns;
  endtask : wait_ev
  always #25ns mclk = ~mclk;
  always @(posedge mclk)
  begin
    nreq <= nreq + (dbg_req === 1'h1);
    nres <= nres + (core_resume === 1'h1);
    width <= (debug_event_pin_oe === 1'h1) ? width + 1 : 0;
    if (debug_event_pin_oe !== 1'h1 && width != 0)
    begin
      ents <= ents + 1;
      chk("ack width", width, 3);
    end
  end
  initial
  begin
    #2ms;
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    void'($urandom(32'hAE240DF1));
    repeat (20) @(posedge mclk);
    #5ns resetn = 1'h1;
    #2us chk("tdo oe reset", tdo_oe, 0);
    jdap_jtag_model_i.walk(8'h00, 1);
    jdap_jtag_model_i.scan(1'h1, `JDAP_IR_DBGSTAT, 4, q, ok);
    chk("ir capture", q, `JDAP_IR_CAPTURE);
    chk("oe in shift", ok, 1);
    chk("oe idle", tdo_oe, 0);
    jdap_jtag_model_i.scan(1'h0, 32'h0, 1, q, ok);
    chk("status idle", q, 0);
    jdap_jtag_model_i.scan(1'h1, `JDAP_IR_DBGCMD, 4, q, ok);
    jdap_jtag_model_i.scan(1'h0, 32'hFFFF_FFFF, 32, q, ok);
    chk("refused", nreq, 0);
    @(posedge mclk) #5ns ext_pull = 1'h1;
    wait_ev(0);
    chk("halt", core_halt_req, 1);
    chk("early entry", core_in_debug, 0);
    core_instr_done = 1'h1;
    wait_ev(1);
    {ext_pull, core_instr_done} = 2'h0;
    jdap_jtag_model_i.scan(1'h1, `JDAP_IR_DBGSTAT, 4, q, ok);
    jdap_jtag_model_i.scan(1'h0, 32'h0, 1, q, ok);
    chk("status debug", q, 1);
    jdap_jtag_model_i.scan(1'h1, `JDAP_IR_DBGCMD, 4, q, ok);
    for (int k = 1; k <= 4; k++)
    begin
      w = $urandom | 32'h0080_0000;
      r = $urandom;
      @(posedge mclk) #5ns dbg_rdata = r;
      jdap_jtag_model_i.scan(1'h0, w, 32, q, ok);
      chk("rdata", q, r);
      chk("addr", dbg_addr, field(w, `JDAP_ADDR_LSB, `JDAP_ADDR_W));
      chk("wdata", dbg_wdata, field(w, `JDAP_WDATA_LSB, `JDAP_WDATA_W));
      chk("we", dbg_we, field(w, `JDAP_CMD_BIT, 1));
      chk("requests", nreq, k);
    end
    for (int k = 0; k < 2; k++)
    begin
      jdap_jtag_model_i.scan(1'h0, 32'h0, 32, q, ok);
      wait_ev(2);
      chk("resumed", core_in_debug, 0);
      chk("resume pulses", nres, k + 1);
      {core_bkpt_hit, core_instr_done} = 2'h3;
      wait_ev(1);
      {core_bkpt_hit, core_instr_done} = 2'h0;
      repeat (6) @(posedge mclk);
      chk("entries", ents, k + 2);
    end
    @(posedge mclk) #5ns dbg_rdata = 32'h1;
    jdap_jtag_model_i.walk(8'h1F, 6);
    jdap_jtag_model_i.scan(1'h0, 32'h3, 2, q, ok);
    chk("bypass", q, 2);
    jdap_jtag_model_i.walk(8'h01, 3);
    #1us chk("oe shift dr", tdo_oe, 1);
    fork
      jdap_jtag_model_i.trst();
      #200ns chk("oe trst", tdo_oe, 0);
    join
    stop_test();
  end
endmodule : jdap_top_tb
